// ===== core/ipl_defs.svh
// register offsets, field positions, reset values and bus codes for the priority level registers
`ifndef IPL_DEFS_SVH
`define IPL_DEFS_SVH

// word indices; byte address is four times the index
`define IPL_IDX_ONE 6'h01
`define IPL_IDX_TWO 6'h02
`define IPL_IDX_THREE 6'h03
`define IPL_IDX_FOUR 6'h04
`define IPL_ADDR_ONE {`IPL_IDX_ONE, 2'b00}
`define IPL_ADDR_TWO {`IPL_IDX_TWO, 2'b00}
`define IPL_ADDR_THREE {`IPL_IDX_THREE, 2'b00}
`define IPL_ADDR_FOUR {`IPL_IDX_FOUR, 2'b00}

// implemented (writable) bits of each register
`define IPL_MASK_ONE 16'h003f
`define IPL_MASK_TWO 16'hffcf
`define IPL_MASK_THREE 16'hfffc
`define IPL_MASK_FOUR 16'hf000

// reset values
`define IPL_RST_ONE 16'h0000
`define IPL_RST_TWO 16'h0000
`define IPL_RST_THREE 16'h0000
`define IPL_RST_FOUR 16'h0000

// field low bit positions
`define IPL_POS_DEBUG_RX_FULL 4
`define IPL_POS_DEBUG_TX_EMPTY 2
`define IPL_POS_DEBUG_TRACE 0
`define IPL_POS_FLASH_BUFFERS_EMPTY 14
`define IPL_POS_FLASH_CMD_DONE 12
`define IPL_POS_FLASH_FAULT 10
`define IPL_POS_PLL_SLIP 8
`define IPL_POS_LOW_SUPPLY 6
`define IPL_POS_EXT_PIN_B 2
`define IPL_POS_EXT_PIN_A 0
`define IPL_POS_PORT_D 14
`define IPL_POS_PORT_E 12
`define IPL_POS_PORT_F 10
`define IPL_POS_CAN_MAILBOX 8
`define IPL_POS_CAN_WAKE 6
`define IPL_POS_CAN_FAULT 4
`define IPL_POS_CAN_BUSOFF 2
`define IPL_POS_SPI_ZERO_RX_FULL 14
`define IPL_POS_SPI_ONE_TX_EMPTY 12

// source indices on the decoded output array
`define IPL_SRC_DEBUG_RX_FULL 0
`define IPL_SRC_DEBUG_TX_EMPTY 1
`define IPL_SRC_DEBUG_TRACE 2
`define IPL_SRC_FLASH_BUFFERS_EMPTY 3
`define IPL_SRC_FLASH_CMD_DONE 4
`define IPL_SRC_FLASH_FAULT 5
`define IPL_SRC_PLL_SLIP 6
`define IPL_SRC_LOW_SUPPLY 7
`define IPL_SRC_EXT_PIN_B 8
`define IPL_SRC_EXT_PIN_A 9
`define IPL_SRC_PORT_D 10
`define IPL_SRC_PORT_E 11
`define IPL_SRC_PORT_F 12
`define IPL_SRC_CAN_MAILBOX 13
`define IPL_SRC_CAN_WAKE 14
`define IPL_SRC_CAN_FAULT 15
`define IPL_SRC_CAN_BUSOFF 16
`define IPL_SRC_SPI_ZERO_RX_FULL 17
`define IPL_SRC_SPI_ONE_TX_EMPTY 18
`define IPL_NUM_SRC 19
`define IPL_NUM_DEBUG 3

// field codes
`define IPL_FIELD_OFF 2'b00

// bus response codes
`define IPL_RESP_OKAY 2'b00
`define IPL_RESP_SLVERR 2'b10

`endif

// ===== core/ipl_pkg.sv
// types shared by the priority level register block
`default_nettype none

package ipl_pkg;

    typedef struct packed {
        logic enable;
        logic [1:0] level;
    } ipl_src_cfg_type;

    typedef struct packed {
        logic [15:0] one;
        logic [15:0] two;
        logic [15:0] three;
        logic [15:0] four;
    } ipl_regs_type;

    typedef enum logic [0:0] {
        IPL_WR_IDLE = 1'b0,
        IPL_WR_RESP = 1'b1
    } ipl_wr_state_type;

    typedef enum logic [0:0] {
        IPL_RD_IDLE = 1'b0,
        IPL_RD_RESP = 1'b1
    } ipl_rd_state_type;

endpackage

`default_nettype wire

// ===== core/ipl_priority_regs.sv
// interrupt priority level registers one to four behind an axi4-lite slave
//
// Operation
// - unused ranges of registers one, two, three read zero, ignore writes
// - debug fields decode 01,10,11 as levels 1,2,3; never level 0
// - peripheral fields decode 01,10,11 as levels 0,1,2; never level 3
// - field 00 disables its source; all fields reset to 00
// - register one bits 5..4 set debug receive-full level
// - register one bits 3..2 set debug transmit-empty level
// - register one bits 1..0 set debug trace buffer level
// - register two bits 15..14 set flash buffers-empty level
// - register two bits 13..12 set flash command-done level
// - register two bits 11..10 set flash error level
// - register two bits 9..8 set pll loss-of-lock level
// - register two bits 7..6 set low voltage detector level
// - register two bits 3..2 pin b, bits 1..0 pin a
// - register three bits 15..14 set port d level
// - register three bits 13..12 set port e level
// - register three bits 11..10 set port f level
// - register three bits 9..8 set can mailbox level
// - register three bits 7..6 set can wake-up level
// - register three bits 5..4 set can error level
// - register three bits 3..2 set can bus-off level
// - register four bits 15..14 set spi zero receive-full level
// - register four bits 13..12 set spi one transmit-empty level
`include "ipl_defs.svh"
`default_nettype none

module ipl_priority_regs (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output ipl_pkg::ipl_src_cfg_type [`IPL_NUM_SRC-1:0] src_cfg
);

    // write channel capture
    logic aw_have_q;
    logic aw_have_d;
    logic [5:0] aw_idx_q;
    logic [5:0] aw_idx_d;
    logic w_have_q;
    logic w_have_d;
    logic [31:0] w_data_q;
    logic [31:0] w_data_d;
    logic [3:0] w_strb_q;
    logic [3:0] w_strb_d;
    logic awready_q;
    logic awready_d;
    logic wready_q;
    logic wready_d;
    logic bvalid_q;
    logic bvalid_d;
    logic [1:0] bresp_q;
    logic [1:0] bresp_d;
    ipl_pkg::ipl_wr_state_type wr_state_q;
    ipl_pkg::ipl_wr_state_type wr_state_d;

    // read channel
    logic arready_q;
    logic arready_d;
    logic rvalid_q;
    logic rvalid_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [1:0] rresp_q;
    logic [1:0] rresp_d;
    ipl_pkg::ipl_rd_state_type rd_state_q;
    ipl_pkg::ipl_rd_state_type rd_state_d;

    // priority registers and decoded outputs
    ipl_pkg::ipl_regs_type regs_q;
    ipl_pkg::ipl_regs_type regs_d;
    logic [1:0] field_d [`IPL_NUM_SRC];
    ipl_pkg::ipl_src_cfg_type [`IPL_NUM_SRC-1:0] cfg_q;
    ipl_pkg::ipl_src_cfg_type [`IPL_NUM_SRC-1:0] cfg_d;

    logic [15:0] lane_mask;
    logic [15:0] wr_val;

    // read mux over the word index
    function automatic logic [16:0] read_word(input logic [5:0] idx, input ipl_pkg::ipl_regs_type r);
        logic [16:0] res;
        res = 17'h00000;
        case (idx)
            `IPL_IDX_ONE: res = {1'b1, r.one & `IPL_MASK_ONE};
            `IPL_IDX_TWO: res = {1'b1, r.two & `IPL_MASK_TWO};
            `IPL_IDX_THREE: res = {1'b1, r.three & `IPL_MASK_THREE};
            `IPL_IDX_FOUR: res = {1'b1, r.four & `IPL_MASK_FOUR};
            default: res = 17'h00000;
        endcase
        return res;
    endfunction

    // write side: capture address and data in either order
    always_comb begin
        aw_have_d = aw_have_q;
        aw_idx_d = aw_idx_q;
        w_have_d = w_have_q;
        w_data_d = w_data_q;
        w_strb_d = w_strb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        wr_state_d = wr_state_q;
        regs_d = regs_q;
        lane_mask = {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
        wr_val = w_data_q[15:0];
        if (s_axi_awvalid && awready_q) begin
            aw_have_d = 1'b1;
            aw_idx_d = s_axi_awaddr[7:2];
        end
        if (s_axi_wvalid && wready_q) begin
            w_have_d = 1'b1;
            w_data_d = s_axi_wdata;
            w_strb_d = s_axi_wstrb;
        end
        case (wr_state_q)
            ipl_pkg::IPL_WR_IDLE: begin
                if (aw_have_q && w_have_q) begin
                    aw_have_d = 1'b0;
                    w_have_d = 1'b0;
                    bvalid_d = 1'b1;
                    bresp_d = `IPL_RESP_OKAY;
                    wr_state_d = ipl_pkg::IPL_WR_RESP;
                    case (aw_idx_q)
                        `IPL_IDX_ONE: begin
                            regs_d.one = (regs_q.one & ~(lane_mask & `IPL_MASK_ONE))
                                | (wr_val & lane_mask & `IPL_MASK_ONE);
                        end
                        `IPL_IDX_TWO: begin
                            regs_d.two = (regs_q.two & ~(lane_mask & `IPL_MASK_TWO))
                                | (wr_val & lane_mask & `IPL_MASK_TWO);
                        end
                        `IPL_IDX_THREE: begin
                            regs_d.three = (regs_q.three & ~(lane_mask & `IPL_MASK_THREE))
                                | (wr_val & lane_mask & `IPL_MASK_THREE);
                        end
                        `IPL_IDX_FOUR: begin
                            regs_d.four = (regs_q.four & ~(lane_mask & `IPL_MASK_FOUR))
                                | (wr_val & lane_mask & `IPL_MASK_FOUR);
                        end
                        default: begin
                            bresp_d = `IPL_RESP_SLVERR;
                        end
                    endcase
                end
            end
            ipl_pkg::IPL_WR_RESP: begin
                if (s_axi_bready) begin
                    bvalid_d = 1'b0;
                    wr_state_d = ipl_pkg::IPL_WR_IDLE;
                end
            end
            default: begin
                bvalid_d = 1'b0;
                wr_state_d = ipl_pkg::IPL_WR_IDLE;
            end
        endcase
        awready_d = ~aw_have_d;
        wready_d = ~w_have_d;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aw_have_q <= 1'b0;
            aw_idx_q <= 6'h00;
            w_have_q <= 1'b0;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= `IPL_RESP_OKAY;
            wr_state_q <= ipl_pkg::IPL_WR_IDLE;
        end else begin
            aw_have_q <= aw_have_d;
            aw_idx_q <= aw_idx_d;
            w_have_q <= w_have_d;
            w_data_q <= w_data_d;
            w_strb_q <= w_strb_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            wr_state_q <= wr_state_d;
        end
    end

    // read side: one read at a time, data registered
    always_comb begin
        logic [16:0] word;
        word = read_word(s_axi_araddr[7:2], regs_q);
        arready_d = arready_q;
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        rd_state_d = rd_state_q;
        case (rd_state_q)
            ipl_pkg::IPL_RD_IDLE: begin
                arready_d = 1'b1;
                if (s_axi_arvalid && arready_q) begin
                    arready_d = 1'b0;
                    rvalid_d = 1'b1;
                    rdata_d = {16'h0000, word[15:0]};
                    rresp_d = word[16] ? `IPL_RESP_OKAY : `IPL_RESP_SLVERR;
                    rd_state_d = ipl_pkg::IPL_RD_RESP;
                end
            end
            ipl_pkg::IPL_RD_RESP: begin
                if (s_axi_rready) begin
                    rvalid_d = 1'b0;
                    arready_d = 1'b1;
                    rd_state_d = ipl_pkg::IPL_RD_IDLE;
                end
            end
            default: begin
                rvalid_d = 1'b0;
                arready_d = 1'b1;
                rd_state_d = ipl_pkg::IPL_RD_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= `IPL_RESP_OKAY;
            rd_state_q <= ipl_pkg::IPL_RD_IDLE;
        end else begin
            arready_q <= arready_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
            rd_state_q <= rd_state_d;
        end
    end

    // field extraction from the next register values
    always_comb begin
        field_d[`IPL_SRC_DEBUG_RX_FULL] = regs_d.one[`IPL_POS_DEBUG_RX_FULL +: 2];
        field_d[`IPL_SRC_DEBUG_TX_EMPTY] = regs_d.one[`IPL_POS_DEBUG_TX_EMPTY +: 2];
        field_d[`IPL_SRC_DEBUG_TRACE] = regs_d.one[`IPL_POS_DEBUG_TRACE +: 2];
        field_d[`IPL_SRC_FLASH_BUFFERS_EMPTY] = regs_d.two[`IPL_POS_FLASH_BUFFERS_EMPTY +: 2];
        field_d[`IPL_SRC_FLASH_CMD_DONE] = regs_d.two[`IPL_POS_FLASH_CMD_DONE +: 2];
        field_d[`IPL_SRC_FLASH_FAULT] = regs_d.two[`IPL_POS_FLASH_FAULT +: 2];
        field_d[`IPL_SRC_PLL_SLIP] = regs_d.two[`IPL_POS_PLL_SLIP +: 2];
        field_d[`IPL_SRC_LOW_SUPPLY] = regs_d.two[`IPL_POS_LOW_SUPPLY +: 2];
        field_d[`IPL_SRC_EXT_PIN_B] = regs_d.two[`IPL_POS_EXT_PIN_B +: 2];
        field_d[`IPL_SRC_EXT_PIN_A] = regs_d.two[`IPL_POS_EXT_PIN_A +: 2];
        field_d[`IPL_SRC_PORT_D] = regs_d.three[`IPL_POS_PORT_D +: 2];
        field_d[`IPL_SRC_PORT_E] = regs_d.three[`IPL_POS_PORT_E +: 2];
        field_d[`IPL_SRC_PORT_F] = regs_d.three[`IPL_POS_PORT_F +: 2];
        field_d[`IPL_SRC_CAN_MAILBOX] = regs_d.three[`IPL_POS_CAN_MAILBOX +: 2];
        field_d[`IPL_SRC_CAN_WAKE] = regs_d.three[`IPL_POS_CAN_WAKE +: 2];
        field_d[`IPL_SRC_CAN_FAULT] = regs_d.three[`IPL_POS_CAN_FAULT +: 2];
        field_d[`IPL_SRC_CAN_BUSOFF] = regs_d.three[`IPL_POS_CAN_BUSOFF +: 2];
        field_d[`IPL_SRC_SPI_ZERO_RX_FULL] = regs_d.four[`IPL_POS_SPI_ZERO_RX_FULL +: 2];
        field_d[`IPL_SRC_SPI_ONE_TX_EMPTY] = regs_d.four[`IPL_POS_SPI_ONE_TX_EMPTY +: 2];
    end

    // per-source decode of enable and level
    for (genvar i = 0; i < `IPL_NUM_SRC; i++) begin : g_dec
        always_comb begin
            cfg_d[i].enable = (field_d[i] != `IPL_FIELD_OFF);
            if (field_d[i] == `IPL_FIELD_OFF) begin
                cfg_d[i].level = 2'b00;
            end else if (i < `IPL_NUM_DEBUG) begin
                cfg_d[i].level = field_d[i];
            end else begin
                cfg_d[i].level = field_d[i] - 2'b01;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            regs_q.one <= `IPL_RST_ONE;
            regs_q.two <= `IPL_RST_TWO;
            regs_q.three <= `IPL_RST_THREE;
            regs_q.four <= `IPL_RST_FOUR;
            cfg_q <= '0;
        end else begin
            regs_q <= regs_d;
            cfg_q <= cfg_d;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign src_cfg = cfg_q;

endmodule

`default_nettype wire

// ===== testbench/ipl_irq_sink.sv
// far-side model: highest level among enabled requesting sources
`include "ipl_defs.svh"
`default_nettype none
module ipl_irq_sink (
    input wire ipl_pkg::ipl_src_cfg_type [`IPL_NUM_SRC-1:0] src_cfg,
    input wire logic [`IPL_NUM_SRC-1:0] req,
    output logic hit,
    output logic [1:0] top_level
);
    timeunit 1ns;
    timeprecision 1ps;
    always_comb begin
        hit = 1'b0;
        top_level = 2'b00;
        for (int i = 0; i < `IPL_NUM_SRC; i++) begin
            if (req[i] && src_cfg[i].enable && (!hit || src_cfg[i].level > top_level)) begin
                hit = 1'b1;
                top_level = src_cfg[i].level;
            end
        end
    end
endmodule
`default_nettype wire

// ===== testbench/ipl_priority_regs_props.sv
// concurrent checks on the priority level register ports
`include "ipl_defs.svh"
`default_nettype none
module ipl_priority_regs_props (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire ipl_pkg::ipl_src_cfg_type [`IPL_NUM_SRC-1:0] src_cfg
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] idx_q;
    logic dbg_bad, per_bad, off_bad;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // index of the read in flight
    always_ff @(posedge clk or posedge rst) begin
        if (rst) idx_q <= 6'h00;
        else if (s_axi_arvalid && s_axi_arready) idx_q <= s_axi_araddr[7:2];
    end
    always_comb begin
        dbg_bad = 1'b0;
        per_bad = 1'b0;
        off_bad = 1'b0;
        for (int i = 0; i < `IPL_NUM_SRC; i++) begin
            if (i < `IPL_NUM_DEBUG && src_cfg[i].enable && src_cfg[i].level == 2'b00) dbg_bad = 1'b1;
            if (i >= `IPL_NUM_DEBUG && src_cfg[i].enable && src_cfg[i].level == 2'b11) per_bad = 1'b1;
            if (!src_cfg[i].enable && src_cfg[i].level != 2'b00) off_bad = 1'b1;
        end
    end
    debug_level_a: assert property (!dbg_bad) else $error("debug source at level zero");
    periph_level_a: assert property (!per_bad) else $error("peripheral at level three");
    off_zero_a: assert property (!off_bad) else $error("disabled source shows level");
    upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("read upper half not zero");
    rsvd_zero_a:
        assert property (s_axi_rvalid |-> (idx_q == `IPL_IDX_ONE ? s_axi_rdata[15:6] == 10'h000
            : idx_q == `IPL_IDX_TWO ? s_axi_rdata[5:4] == 2'h0 : idx_q != `IPL_IDX_THREE || s_axi_rdata[1:0] == 2'h0))
        else $error("unused bits read nonzero");
    debug_map_a:
        assert property ($rose(s_axi_rvalid) && idx_q == `IPL_IDX_ONE |->
            src_cfg[0].level == s_axi_rdata[5:4] && src_cfg[0].enable == |s_axi_rdata[5:4])
        else $error("receive-full level differs");
    flash_map_a:
        assert property ($rose(s_axi_rvalid) && idx_q == `IPL_IDX_TWO |->
            src_cfg[5] == (s_axi_rdata[11:10] == 2'h0 ? 3'h0 : {1'b1, s_axi_rdata[11:10] - 2'h1}))
        else $error("flash fault level differs");
    cfg_write_a: assert property (!$stable(src_cfg) |-> $rose(s_axi_bvalid))
        else $error("setting changed without write");
    cover property (s_axi_bvalid && s_axi_bresp == `IPL_RESP_SLVERR);
    cover property (s_axi_rvalid && s_axi_rdata[15:0] == `IPL_MASK_TWO);
    cover property (src_cfg[0].level == 2'b11);
endmodule
bind ipl_priority_regs ipl_priority_regs_props u_ipl_priority_regs_props (.clk(clk), .rst(rst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arprot(s_axi_arprot), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .src_cfg(src_cfg));
`default_nettype wire

// ===== testbench/tb_irq_priority_level_regs.sv
// self-checking bench for the priority level registers
`include "ipl_defs.svh"
`default_nettype none
module tb_irq_priority_level_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, hit;
    logic [1:0] bresp, rresp, top_level;
    logic [31:0] rdata;
    logic [`IPL_NUM_SRC-1:0] req = '1;
    ipl_pkg::ipl_src_cfg_type [`IPL_NUM_SRC-1:0] src_cfg;
    logic [15:0] shadow [1:4];
    int err_count = 0;
    int checks_done = 0;
    localparam int RG [19] = '{1, 1, 1, 2, 2, 2, 2, 2, 2, 2, 3, 3, 3, 3, 3, 3, 3, 4, 4};
    localparam int PS [19] = '{4, 2, 0, 14, 12, 10, 8, 6, 2, 0, 14, 12, 10, 8, 6, 4, 2, 14, 12};
    localparam logic [15:0] MASK [1:4] = '{`IPL_MASK_ONE, `IPL_MASK_TWO, `IPL_MASK_THREE, `IPL_MASK_FOUR};
    always #20 clk = ~clk;
    ipl_priority_regs u_ipl_priority_regs (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .src_cfg(src_cfg));
    ipl_irq_sink u_ipl_irq_sink (.src_cfg(src_cfg), .req(req), .hit(hit), .top_level(top_level));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic wr(input logic [5:0] idx, input logic [31:0] d, output logic [1:0] r);
        logic ad, dd;
        ad = 1'b0;
        dd = 1'b0;
        awaddr <= {idx, 2'b00};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(ad && dd)) begin
            @(posedge clk);
            if (!ad && awready) begin
                ad = 1'b1;
                awvalid <= 1'b0;
            end
            if (!dd && wready) begin
                dd = 1'b1;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b1;
        do @(posedge clk); while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] idx, output logic [31:0] d, output logic [1:0] r);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do @(posedge clk); while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    function automatic logic [2:0] exp_cfg(input int j);
        logic [1:0] f;
        f = shadow[RG[j]][PS[j] +: 2];
        if (f == 2'b00) return 3'h0;
        return {1'b1, (j < `IPL_NUM_DEBUG) ? f : f - 2'b01};
    endfunction
    task automatic check_all();
        logic [2:0] e;
        logic [31:0] d;
        logic [1:0] r, top;
        logic any;
        top = 2'b00;
        any = 1'b0;
        for (int j = 0; j < `IPL_NUM_SRC; j++) begin
            e = exp_cfg(j);
            if (req[j] && e[2] && (!any || e[1:0] > top)) begin
                any = 1'b1;
                top = e[1:0];
            end
            if (j < 3) chk({29'h0, src_cfg[j]}, {29'h0, e}, "debug level");
            else if (j < 10) chk({29'h0, src_cfg[j]}, {29'h0, e}, "two");
            else chk({29'h0, src_cfg[j]}, {29'h0, e}, "three four");
        end
        chk({30'h0, hit, any}, {30'h0, any, any}, "sink hit");
        chk({30'h0, top_level}, {30'h0, top}, "sink level");
        for (int i = 1; i <= 4; i++) begin
            rd(6'(i), d, r);
            chk({30'h0, r}, {30'h0, `IPL_RESP_OKAY}, "read resp");
            chk(d, {16'h0000, shadow[i]}, "read data");
        end
    endtask
    task automatic put(input int i, input logic [31:0] d);
        logic [1:0] r;
        logic [15:0] lanes;
        wr(6'(i), d, r);
        chk({30'h0, r}, {30'h0, `IPL_RESP_OKAY}, "write resp");
        lanes = {{8{wstrb[1]}}, {8{wstrb[0]}}};
        shadow[i] = (shadow[i] & ~lanes) | (d[15:0] & lanes & MASK[i]);
        check_all();
    endtask
    task automatic t_reset();
        for (int i = 1; i <= 4; i++) shadow[i] = 16'h0000;
        check_all();
        $display("reset values done");
    endtask
    task automatic t_codes();
        for (int c = 1; c < 5; c++)
            for (int i = 1; i <= 4; i++) put(i, {16'hffff, {8{c[1:0]}}});
        for (int i = 1; i <= 4; i++) put(i, 32'hffff_ffff);
        $display("field codes done");
    endtask
    task automatic t_fields();
        for (int j = 0; j < `IPL_NUM_SRC; j++) put(RG[j], 32'h2 << PS[j]);
        $display("field positions done");
    endtask
    task automatic t_lanes();
        put(1, 32'h0000_0030);
        put(2, 32'h0000_c0ff);
        wstrb <= 4'h1;
        put(2, 32'h0000_ff00);
        wstrb <= 4'h2;
        put(2, 32'h0000_8041);
        wstrb <= 4'hf;
        req <= 19'h00008;
        @(posedge clk);
        check_all();
        req <= '1;
        @(posedge clk);
        $display("byte lanes and request mask done");
    endtask
    task automatic t_unmapped();
        logic [5:0] bad [3] = '{6'h00, 6'h05, 6'h3f};
        logic [31:0] d;
        logic [1:0] r;
        foreach (bad[k]) begin
            wr(bad[k], 32'hffff_ffff, r);
            chk({30'h0, r}, {30'h0, `IPL_RESP_SLVERR}, "unmapped write");
            rd(bad[k], d, r);
            chk({d[29:0], r}, {30'h0, `IPL_RESP_SLVERR}, "unmapped read");
        end
        check_all();
        $display("unmapped done");
    endtask
    task automatic t_midreset();
        put(2, 32'h0000_aaaa);
        rst <= 1'b1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_reset();
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #(40 * 30000);
        err_count++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        print_verdict();
    end
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_codes();
        t_fields();
        t_lanes();
        t_unmapped();
        t_midreset();
        print_verdict();
    end
endmodule
`default_nettype wire
